// ### psl_pkg.sv
`default_nettype none
package psl_pkg;
	// Key values that must reach the lock register back to back.
	localparam logic [7:0] KEY_FIRST     = 8'h55;
	localparam logic [7:0] KEY_SECOND    = 8'hAA;
	// Bit of the lock register that holds the selection locked flag.
	localparam int         LOCK_BIT      = 0;
	localparam logic       LOCK_RST      = 1'b0;
	// Selector widths and fields.
	localparam int         OUT_SEL_W     = 6;
	localparam int         IN_SEL_W      = 5;
	localparam int         IN_PORT_LSB   = 3;
	localparam int         IN_PORT_MSB   = 4;
	localparam int         IN_PIN_MSB    = 2;
	// Power-on values of the selectors.
	localparam logic [5:0] OUT_SEL_RST   = 6'h00;
	localparam logic [4:0] IN_SEL_RST    = 5'h00;
	// Output source codes with special handling.
	localparam logic [5:0] OUT_SEL_NONE  = 6'h00;
	localparam logic [5:0] OUT_SEL_MAX   = 6'h20;
	localparam logic [5:0] CODE_UART_CK  = 6'h0F;
	localparam logic [5:0] CODE_UART_DT  = 6'h10;
	localparam logic [5:0] CODE_SER1_CK  = 6'h13;
	localparam logic [5:0] CODE_SER1_DO  = 6'h14;
	localparam logic [5:0] CODE_SER2_CK  = 6'h15;
	localparam logic [5:0] CODE_SER2_DO  = 6'h16;

	typedef enum logic [1:0] {
		KEY_IDLE  = 2'b00,
		KEY_GOT1  = 2'b01,
		KEY_ARMED = 2'b10
	} psl_key_state_t;
endpackage
`default_nettype wire

// ### psl_lock_if.sv
`timescale 1ns/1ns
`default_nettype none
// Carries lock register traffic between the crossbar and its lock controller.
interface psl_lock_if;
	logic       lock_wr;
	logic [7:0] lock_wdata;
	logic       sel_wr;
	logic       one_shot;
	logic       locked;
	logic       set_once;

	modport ctl (
		input  lock_wr,
		input  lock_wdata,
		input  sel_wr,
		input  one_shot,
		output locked,
		output set_once
	);
	modport top (
		output lock_wr,
		output lock_wdata,
		output sel_wr,
		output one_shot,
		input  locked,
		input  set_once
	);
endinterface
`default_nettype wire

// ### psl_lock_ctl.sv
`timescale 1ns/1ns
`default_nettype none
// Key sequence detector and selection locked flag with one-shot history.
module psl_lock_ctl (
	input  wire logic clk,
	input  wire logic rst,
	psl_lock_if.ctl   lk
);
	import psl_pkg::*;

	psl_key_state_t state_r, state_nxt;
	logic           locked_r, locked_nxt;
	logic           once_r, once_nxt;
	logic           want;

	// Next state: only a lock write in the armed state may move the flag.
	always_comb begin
		state_nxt  = state_r;
		locked_nxt = locked_r;
		once_nxt   = once_r;
		want       = lk.lock_wdata[LOCK_BIT];
		if (lk.sel_wr) begin
			// Any other write between the keys breaks the sequence.
			state_nxt = KEY_IDLE;
		end else if (lk.lock_wr) begin
			case (state_r)
				KEY_IDLE: begin
					state_nxt = (lk.lock_wdata == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
				end
				KEY_GOT1: begin
					state_nxt = (lk.lock_wdata == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
				end
				KEY_ARMED: begin
					state_nxt = KEY_IDLE;
					if (want) begin
						locked_nxt = 1'b1;
						// Record the first set so one-shot mode can refuse a clear.
						if (lk.one_shot) begin
							once_nxt = 1'b1;
						end
					end else if (!(lk.one_shot && once_r)) begin
						locked_nxt = 1'b0;
					end
				end
				default: begin
					state_nxt = KEY_IDLE;
				end
			endcase
		end
	end

	// Power-on reset is the only reset that clears the flag and the one-shot history.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r  <= KEY_IDLE;
			locked_r <= LOCK_RST;
			once_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			locked_r <= locked_nxt;
			once_r   <= once_nxt;
		end
	end

	assign lk.locked   = locked_r;
	assign lk.set_once = once_r;
endmodule // psl_lock_ctl
`default_nettype wire

// ### psl_crossbar.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Each pin's 6-bit output code picks peripheral output 1 to 32 for that pin.
// - Second serial data and clock codes route only on the 20-pin variant.
// - While locked, all selector writes are ignored and routing stays unchanged.
// - Flag changes only after writing 0x55 then 0xAA, then the flag write.
// - With one-shot option set, the flag cannot be cleared once it has been set with that option set after reset.
// - With one-shot option clear, the flag may change repeatedly after each key sequence.
// - Selector values are always readable regardless of lock or one-shot option.
// - Sleep entry or exit leaves every selection untouched.
// - Power-on reset returns every selector to its default value.
// - Other resets leave every selector at its current value.
// - Power-on reset also clears the one-shot lock history.
// - Input code holds port in bits 4:3 and pin number in bits 2:0.
// - Direction control keeps the driver, except for sync UART and I2C.
module psl_crossbar #(
	parameter int NUM_PINS   = 18,
	parameter int NUM_INSEL  = 24,
	parameter bit TWENTY_PIN = 1'b1
) (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	input  wire logic                                 one_shot_lock_option,
	input  wire logic                                 lock_wr,
	input  wire logic [7:0]                           lock_wdata,
	output logic                                      selection_locked_flag,
	output logic                                      one_shot_used,
	input  wire logic                                 sel_wr,
	input  wire logic                                 sel_is_input,
	input  wire logic [4:0]                           sel_idx,
	input  wire logic [psl_pkg::OUT_SEL_W-1:0]        sel_wdata,
	output logic [NUM_PINS*psl_pkg::OUT_SEL_W-1:0]    out_sel_rd,
	output logic [NUM_INSEL*psl_pkg::IN_SEL_W-1:0]    in_sel_rd,
	input  wire logic [31:0]                          periph_out,
	input  wire logic [31:0]                          periph_drive_en,
	input  wire logic [NUM_PINS-1:0]                  port_latch,
	input  wire logic [NUM_PINS-1:0]                  pin_direction_control,
	output logic [NUM_PINS-1:0]                       pin_out,
	output logic [NUM_PINS-1:0]                       pin_oe,
	input  wire logic [31:0]                          pin_in,
	output logic [NUM_INSEL-1:0]                      periph_in
);
	import psl_pkg::*;

	psl_lock_if lk ();

	// Tells whether an output code belongs to a peripheral that steers its own driver.
	function automatic logic is_bidir(input logic [OUT_SEL_W-1:0] code);
		is_bidir = (code == CODE_UART_CK) || (code == CODE_UART_DT) ||
			(code == CODE_SER1_CK) || (code == CODE_SER1_DO) ||
			(code == CODE_SER2_CK) || (code == CODE_SER2_DO);
	endfunction

	// Tells whether an output code may be routed on this package variant.
	function automatic logic code_ok(input logic [OUT_SEL_W-1:0] code);
		logic ser2;
		ser2 = (code == CODE_SER2_CK) || (code == CODE_SER2_DO);
		code_ok = (code != OUT_SEL_NONE) && (code <= OUT_SEL_MAX) && (!ser2 || TWENTY_PIN);
	endfunction

	assign lk.lock_wr    = lock_wr;
	assign lk.lock_wdata = lock_wdata;
	assign lk.sel_wr     = sel_wr;
	assign lk.one_shot   = one_shot_lock_option;

	psl_lock_ctl u_lock (
		.clk (clk),
		.rst (rst),
		.lk  (lk)
	);

	assign selection_locked_flag = lk.locked;
	assign one_shot_used         = lk.set_once;

	logic [OUT_SEL_W-1:0] out_sel_r   [NUM_PINS];
	logic [OUT_SEL_W-1:0] out_sel_nxt [NUM_PINS];
	logic [IN_SEL_W-1:0]  in_sel_r    [NUM_INSEL];
	logic [IN_SEL_W-1:0]  in_sel_nxt  [NUM_INSEL];
	logic [NUM_PINS-1:0]  pin_out_r, pin_out_nxt;
	logic [NUM_PINS-1:0]  pin_oe_r, pin_oe_nxt;
	logic [NUM_INSEL-1:0] periph_in_r, periph_in_nxt;

	// Selector writes land only while unlocked; a locked write is simply dropped.
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			out_sel_nxt[i] = out_sel_r[i];
			if (sel_wr && !sel_is_input && !lk.locked && (int'(sel_idx) == i)) begin
				out_sel_nxt[i] = sel_wdata;
			end
		end
		for (int j = 0; j < NUM_INSEL; j++) begin
			in_sel_nxt[j] = in_sel_r[j];
			if (sel_wr && sel_is_input && !lk.locked && (int'(sel_idx) == j)) begin
				in_sel_nxt[j] = sel_wdata[IN_SEL_W-1:0];
			end
		end
	end

	// The selectors see only the power-on reset; sleep and other resets have no path here.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				out_sel_r[i] <= OUT_SEL_RST;
			end
			for (int j = 0; j < NUM_INSEL; j++) begin
				in_sel_r[j] <= IN_SEL_RST;
			end
		end else begin
			// No sleep or warm reset input reaches these flops, so selections hold.
			out_sel_r <= out_sel_nxt;
			in_sel_r  <= in_sel_nxt;
		end
	end

	// Read-back is a plain view of the stored codes, never gated by the lock.
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_out_rd
			assign out_sel_rd[g*OUT_SEL_W +: OUT_SEL_W] = out_sel_r[g];
		end
		for (g = 0; g < NUM_INSEL; g++) begin : g_in_rd
			assign in_sel_rd[g*IN_SEL_W +: IN_SEL_W] = in_sel_r[g];
		end
	endgenerate

	// Output routing and driver enable for every pin.
	always_comb begin
		logic [OUT_SEL_W-1:0] code;
		code = OUT_SEL_NONE;
		for (int i = 0; i < NUM_PINS; i++) begin
			code = out_sel_r[i];
			if (code_ok(code)) begin
				pin_out_nxt[i] = periph_out[code[4:0] - 5'd1];
			end else begin
				// Unrouted and variant-illegal codes fall back to the port latch.
				pin_out_nxt[i] = port_latch[i];
			end
			if (code_ok(code) && is_bidir(code)) begin
				pin_oe_nxt[i] = periph_drive_en[code[4:0] - 5'd1];
			end else begin
				pin_oe_nxt[i] = !pin_direction_control[i];
			end
		end
	end

	// Input routing: port and pin fields address the packed pin input vector.
	always_comb begin
		for (int j = 0; j < NUM_INSEL; j++) begin
			periph_in_nxt[j] = pin_in[{in_sel_r[j][IN_PORT_MSB:IN_PORT_LSB],
				in_sel_r[j][IN_PIN_MSB:0]}];
		end
	end

	// Routed data is registered, costing one cycle of latency on every path.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out_r   <= '0;
			pin_oe_r    <= '0;
			periph_in_r <= '0;
		end else begin
			pin_out_r   <= pin_out_nxt;
			pin_oe_r    <= pin_oe_nxt;
			periph_in_r <= periph_in_nxt;
		end
	end

	assign pin_out   = pin_out_r;
	assign pin_oe    = pin_oe_r;
	assign periph_in = periph_in_r;
endmodule // psl_crossbar
`default_nettype wire

// ### psl_periph_model.sv
`timescale 1ns/1ns
`default_nettype none
// Peripheral and pad side: every line is drawn from one counter that steps by an odd amount each cycle.
module psl_periph_model (
	input  wire logic   clk,
	output logic [31:0] periph_out,
	output logic [31:0] periph_drive_en,
	output logic [31:0] pin_in
);
	logic [31:0] cnt_r = 32'h0;
	logic [31:0] cnt_nxt;
	// An odd step gives each bit its own toggle pattern.
	always_comb cnt_nxt = cnt_r + 32'h9E3779B9;
	always_ff @(posedge clk) cnt_r <= cnt_nxt;
	// Rotations keep enables and pad levels unlike the outputs.
	assign periph_out = cnt_r;
	assign periph_drive_en = {cnt_r[15:0], cnt_r[31:16]};
	assign pin_in = ~{cnt_r[7:0], cnt_r[31:8]};
endmodule // psl_periph_model
`default_nettype wire

// ### psl_crossbar_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Watches lock handling and the routing of pin 0 and input 0.
module psl_crossbar_sva import psl_pkg::*; #(
	parameter int NUM_PINS   = 18,
	parameter int NUM_INSEL  = 24,
	parameter bit TWENTY_PIN = 1'b1
) (
	input wire logic                             clk,
	input wire logic                             rst,
	input wire logic                             one_shot_lock_option,
	input wire logic                             lock_wr,
	input wire logic [7:0]                       lock_wdata,
	input wire logic                             selection_locked_flag,
	input wire logic                             one_shot_used,
	input wire logic                             sel_wr,
	input wire logic                             sel_is_input,
	input wire logic [4:0]                       sel_idx,
	input wire logic [psl_pkg::OUT_SEL_W-1:0]    sel_wdata,
	input wire logic [NUM_PINS*psl_pkg::OUT_SEL_W-1:0] out_sel_rd,
	input wire logic [NUM_INSEL*psl_pkg::IN_SEL_W-1:0] in_sel_rd,
	input wire logic [31:0]                      periph_out,
	input wire logic [NUM_PINS-1:0]              port_latch,
	input wire logic [NUM_PINS-1:0]              pin_direction_control,
	input wire logic [NUM_PINS-1:0]              pin_out,
	input wire logic [NUM_PINS-1:0]              pin_oe,
	input wire logic [31:0]                      pin_in,
	input wire logic [NUM_INSEL-1:0]             periph_in
);
	logic [1:0] ks_r;
	logic [1:0] ks_nxt;
	wire lk = selection_locked_flag;
	wire [5:0] c0 = out_sel_rd[5:0];
	wire rt = periph_out[c0 - 6'h01];
	wire ir = pin_in[in_sel_rd[4:0]];
	wire bd = c0 inside {CODE_UART_CK, CODE_UART_DT, CODE_SER1_CK, CODE_SER1_DO,
		CODE_SER2_CK, CODE_SER2_DO};
	// Own copy of the key detector; a selector write breaks the sequence.
	always_comb begin
		ks_nxt = ks_r;
		if (sel_wr) ks_nxt = 2'h0;
		else if (lock_wr) ks_nxt = (ks_r == 2'h0 && lock_wdata == KEY_FIRST) ? 2'h1 :
			(ks_r == 2'h1 && lock_wdata == KEY_SECOND) ? 2'h2 : 2'h0;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) ks_r <= 2'h0;
		else ks_r <= ks_nxt;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_lock_freeze: assert property (lk && sel_wr |=> $stable(out_sel_rd) && $stable(in_sel_rd))
		else $error("selector changed while locked");
	a_out_store: assert property (!lk && sel_wr && !sel_is_input && sel_idx < NUM_PINS
		|=> out_sel_rd[$past(sel_idx)*6 +: 6] == $past(sel_wdata)) else $error("output code lost");
	a_key_gate: assert property ($changed(lk) |-> $past(lock_wr && ks_r == 2'h2))
		else $error("flag moved without key");
	a_flag_take: assert property (lock_wr && !sel_wr && ks_r == 2'h2 && !one_shot_lock_option
		|=> lk == $past(lock_wdata[0])) else $error("flag write not taken");
	a_one_way: assert property (one_shot_lock_option && one_shot_used && lk |=> lk)
		else $error("one-shot lock cleared");
	a_used_cause: assert property ($rose(one_shot_used) |-> $past(one_shot_lock_option) && lk)
		else $error("one-shot mark without set");
	a_zero_latch: assert property (c0 == 6'h00 |=> pin_out[0] == $past(port_latch[0]))
		else $error("code zero not latch");
	a_route_pin: assert property (c0 inside {[6'h01:6'h20]} |=> pin_out[0] == $past(rt))
		else $error("pin not routed");
	a_dir_keeps: assert property (!bd |=> pin_oe[0] == !$past(pin_direction_control[0]))
		else $error("direction lost driver");
	a_in_route: assert property (1'b1 |=> periph_in[0] == $past(ir))
		else $error("input not routed");
	c_locked_wr: cover property (lk && sel_wr);
	c_one_shot: cover property ($rose(one_shot_used));
	c_unlock: cover property ($fell(lk));
endmodule // psl_crossbar_sva
bind psl_crossbar psl_crossbar_sva #(.NUM_PINS(NUM_PINS), .NUM_INSEL(NUM_INSEL),
	.TWENTY_PIN(TWENTY_PIN)) u_psl_crossbar_sva (.*);
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import psl_pkg::*;
	logic clk, rst, one_shot_lock_option, lock_wr, sel_wr, sel_is_input;
	logic [7:0] lock_wdata;
	logic [4:0] sel_idx;
	logic [5:0] sel_wdata;
	logic [107:0] out_sel_rd, exp_o;
	logic [119:0] in_sel_rd, exp_i;
	logic [31:0] periph_out, periph_drive_en, pin_in;
	logic [17:0] port_latch, pin_direction_control, pin_out, pin_oe;
	logic [23:0] periph_in;
	logic [1:0] exp_f;
	logic selection_locked_flag, one_shot_used;
	int failures, n_checks;
	psl_crossbar u_psl_crossbar (.clk(clk), .rst(rst), .one_shot_lock_option(one_shot_lock_option),
		.lock_wr(lock_wr), .lock_wdata(lock_wdata), .selection_locked_flag(selection_locked_flag),
		.one_shot_used(one_shot_used), .sel_wr(sel_wr), .sel_is_input(sel_is_input),
		.sel_idx(sel_idx), .sel_wdata(sel_wdata), .out_sel_rd(out_sel_rd), .in_sel_rd(in_sel_rd),
		.periph_out(periph_out), .periph_drive_en(periph_drive_en), .port_latch(port_latch),
		.pin_direction_control(pin_direction_control), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_in(pin_in), .periph_in(periph_in));
	psl_periph_model u_psl_periph_model (.clk(clk), .periph_out(periph_out),
		.periph_drive_en(periph_drive_en), .pin_in(pin_in));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Latch and direction keep moving so the zero code and driver control are exercised.
	always @(posedge clk) begin
		port_latch <= {port_latch[16:0], ~port_latch[17]};
		pin_direction_control <= pin_direction_control + 18'h00001;
	end
	task automatic chk(input logic [119:0] got, input logic [119:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic swr(input logic in_, input logic [4:0] ix, input logic [5:0] d);
		@(posedge clk);
		{sel_wr, sel_is_input, sel_idx, sel_wdata} <= {1'b1, in_, ix, d};
		@(posedge clk);
		sel_wr <= 1'b0;
		if (!exp_f[0] && in_ && ix < 5'h18) exp_i[ix*5 +: 5] = d[4:0];
		if (!exp_f[0] && !in_ && ix < 5'h12) exp_o[ix*6 +: 6] = d;
	endtask
	// The three lock writes go out back to back, as with interrupts held off.
	task automatic lseq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] d);
		@(posedge clk);
		{lock_wr, lock_wdata} <= {1'b1, a};
		@(posedge clk);
		lock_wdata <= b;
		@(posedge clk);
		lock_wdata <= d;
		@(posedge clk);
		lock_wr <= 1'b0;
		if (a == KEY_FIRST && b == KEY_SECOND && !(one_shot_lock_option && exp_f[1] && !d[0]))
			exp_f = {exp_f[1] | (one_shot_lock_option & d[0]), d[0]};
	endtask
	task automatic rdchk;
		@(negedge clk);
		chk(out_sel_rd, exp_o);
		chk(in_sel_rd, exp_i);
		chk({one_shot_used, selection_locked_flag}, exp_f);
	endtask
	// Snapshot the far side, then compare the registered pins one cycle on.
	task automatic rchk;
		logic [31:0] po, de, pi;
		logic [17:0] pl, dr, eo, ee;
		logic [23:0] ei;
		logic [5:0] c;
		@(negedge clk);
		{po, de, pi, pl, dr} = {periph_out, periph_drive_en, pin_in, port_latch, pin_direction_control};
		for (int i = 0; i < 18; i++) begin
			c = exp_o[i*6 +: 6];
			eo[i] = (c >= 6'h01 && c <= 6'h20) ? po[c - 6'h01] : pl[i];
			ee[i] = (c inside {CODE_UART_CK, CODE_UART_DT, CODE_SER1_CK, CODE_SER1_DO,
				CODE_SER2_CK, CODE_SER2_DO}) ? de[c - 6'h01] : !dr[i];
		end
		for (int j = 0; j < 24; j++) ei[j] = pi[exp_i[j*5 +: 5]];
		@(negedge clk);
		chk(pin_out, eo);
		chk(pin_oe, ee);
		chk(periph_in, ei);
	endtask
	task automatic finish_test;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// A hung handshake would stall the sequence; cut it off well past the expected length.
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		finish_test;
	end
	initial begin
		{rst, lock_wr, sel_wr, sel_is_input, one_shot_lock_option} = 5'h10;
		{lock_wdata, sel_idx, sel_wdata} = 19'h0;
		{port_latch, pin_direction_control} = {18'h00F0F, 18'h0};
		{exp_o, exp_i, exp_f, failures, n_checks} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdchk;
		for (int i = 0; i < 18; i++) swr(1'b0, 5'(i), 6'(i + 1));
		rchk;
		for (int i = 0; i < 18; i++) swr(1'b0, 5'(i), 6'(i + 15));
		rchk;
		swr(1'b0, 5'h00, 6'h21);
		swr(1'b0, 5'h12, 6'h07);
		rchk;
		for (int j = 0; j < 24; j++) swr(1'b1, 5'(j), 6'(j + 8));
		rchk;
		lseq(KEY_FIRST, KEY_SECOND, 8'h01);
		rdchk;
		swr(1'b0, 5'h01, 6'h03);
		swr(1'b1, 5'h02, 6'h1F);
		rdchk;
		rchk;
		lseq(KEY_FIRST, KEY_FIRST, 8'h00);
		rdchk;
		lseq(KEY_FIRST, KEY_SECOND, 8'h00);
		swr(1'b0, 5'h01, 6'h03);
		swr(1'b0, 5'h03, CODE_UART_DT);
		swr(1'b1, 5'h10, 6'h03);
		rdchk;
		rchk;
		lseq(KEY_FIRST, KEY_SECOND, 8'h01);
		lseq(KEY_FIRST, KEY_SECOND, 8'h00);
		rdchk;
		@(posedge clk);
		one_shot_lock_option <= 1'b1;
		lseq(KEY_FIRST, KEY_SECOND, 8'h01);
		lseq(KEY_FIRST, KEY_SECOND, 8'h00);
		rdchk;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		{exp_o, exp_i, exp_f} = '0;
		rdchk;
		lseq(KEY_FIRST, KEY_SECOND, 8'h01);
		rdchk;
		finish_test;
	end
endmodule // tb_top
`default_nettype wire
